// >>> ufis_host.sv
`default_nettype none
module ufis_host (
   input  wire logic                 clk,
   output ufis_pkg::ufis_event_t     ev
);
   timeunit 1ns;
   timeprecision 1ps;
   initial ev = '0;
   task automatic pulse(input int i);
      @(posedge clk) ev[i] <= 1'b1;
      @(posedge clk) ev[i] <= 1'b0;
   endtask : pulse
   // Count is the level before the arriving byte
   task automatic fill(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge clk) ev.rx_count <= 7'(k);
         ev.rx_byte <= 1'b1;
         @(posedge clk) ev.rx_byte <= 1'b0;
      end
   endtask : fill
endmodule : ufis_host
`default_nettype wire

// >>> ufis_pkg.sv
`default_nettype none
package ufis_pkg;
   localparam logic [15:0] OFS_STATUS_FIRST  = 16'h4004;
   localparam logic [15:0] OFS_FIFO_ENABLE   = 16'h4006;
   localparam logic [15:0] OFS_EVENT_ENABLE  = 16'h4002;
   localparam logic [15:0] OFS_STATUS_SECOND = 16'h4008;
   localparam logic [15:0] OFS_RX_THRESHOLD  = 16'h400c;
   localparam logic [15:0] OFS_IRQ_MASK      = 16'h4010;

   localparam int BIT_SUSPEND = 7;
   localparam int BIT_SOF     = 6;
   localparam int BIT_EP4     = 4;
   localparam int BIT_EP3     = 3;
   localparam int BIT_EP2     = 2;
   localparam int BIT_EP1     = 1;
   localparam int BIT_UPPER   = 0;
   localparam int BIT_RX_FULL = 0;
   localparam int BIT_TX_MTY  = 1;

   localparam logic [7:0] FIRST_W1C_MASK  = 8'hde;
   localparam logic [1:0] SECOND_W1C_MASK = 2'h3;
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam logic [6:0] RESET_THRESHOLD = 7'h00;
   localparam logic [1:0] RESET_MASK      = 2'h3;

   typedef struct packed {
      logic       suspend_req;
      logic       sof;
      logic       ep4_sent;
      logic       ep3_rcvd;
      logic       ep2_read;
      logic       ep1_written;
      logic       rx_byte;
      logic       tx_byte;
      logic [6:0] rx_count;
      logic [6:0] tx_count;
   } ufis_event_t;
endpackage : ufis_pkg
`default_nettype wire

// >>> ufis_sva.sv
`default_nettype none
module ufis_sva (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [15:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire ufis_pkg::ufis_event_t usb_ev,
   input wire logic                  irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ev_any;
   logic wr_acc;
   assign ev_any = |usb_ev[21:14];
   assign wr_acc = psel && penable && pwrite;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd(a);
      psel && !penable && !pwrite && paddr == a ##1 penable;
   endsequence
   sequence s_clr;
      wr_acc && paddr == 16'h4004 && pwdata[7] && !usb_ev.suspend_req
      ##1 !usb_ev.suspend_req;
   endsequence
   // Quiet cycle between event and setup, no clearing write in between
   property p_sus;
      usb_ev.suspend_req ##1 !wr_acc ##1 s_rd(16'h4004) |-> prdata[7];
   endproperty
   property p_clr;
      s_clr ##1 s_rd(16'h4004) |-> !prdata[7];
   endproperty
   property p_sof;
      usb_ev.sof ##1 !wr_acc ##1 s_rd(16'h4004) |-> prdata[6];
   endproperty
   property p_ep2;
      usb_ev.ep2_read ##1 !wr_acc ##1 s_rd(16'h4004) |-> prdata[2];
   endproperty
   property p_ep1;
      usb_ev.ep1_written ##1 !wr_acc ##1 s_rd(16'h4004) |-> prdata[1];
   endproperty
   property p_rise;
      $rose(irq) |-> $past(ev_any) || $past(ev_any, 2) || $past(wr_acc)
         || $past(wr_acc, 2);
   endproperty
   property p_fall;
      $fell(irq) |-> $past(wr_acc) || $past(wr_acc, 2);
   endproperty
   property p_unm;
      psel && penable && paddr == 16'h4020 |-> pslverr && prdata == 32'h0;
   endproperty
   a_sus: assert property (p_sus)
      else $error("suspend flag missing");
   a_clr: assert property (p_clr)
      else $error("suspend flag not cleared");
   a_sof: assert property (p_sof)
      else $error("frame flag missing");
   a_ep2: assert property (p_ep2)
      else $error("ep2 flag missing");
   a_ep1: assert property (p_ep1)
      else $error("ep1 flag missing");
   a_rise: assert property (p_rise)
      else $error("irq rose without cause");
   a_fall: assert property (p_fall)
      else $error("irq fell without write");
   a_unm: assert property (p_unm)
      else $error("unmapped access not refused");
endmodule : ufis_sva
`default_nettype wire

// >>> ufis_tb.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, se;
   logic [15:0]           paddr;
   logic [31:0]           pwdata, prdata, rd, d;
   ufis_pkg::ufis_event_t usb_ev;
   int err_total, samples_checked, s1, s2, en1, fen;
   int bits[6] = '{7, 6, 4, 3, 2, 1};
   int evi[6] = '{21, 20, 19, 18, 17, 16};
   ufis_top uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .usb_ev(usb_ev), .irq(irq));
   ufis_host host (.clk(clk), .ev(usb_ev));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [31:0] v);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk);
      while (pready !== 1'b1 && n++ < 20);
      if (n >= 20) begin
         err_total++;
         stop_test();
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
   function automatic logic irq_exp();
      return (|(s1 & en1 & 'hde)) | (|(s2 & fen & 3));
   endfunction : irq_exp
   initial begin
      {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
      {err_total, samples_checked, s1, s2, en1, fen} = '0;
      void'($urandom(66590));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      xfer(0, 16'h4004, 0);
      chk(rd, 0);
      $display("test reset done");
      foreach (bits[j]) begin
         en1 = $urandom & 'hde;
         xfer(1, 16'h4002, en1);
         host.pulse(evi[j]);
         s1 |= 1 << bits[j];
         xfer(0, 16'h4004, 0);
         chk(rd, s1);
         chk(irq, irq_exp());
         d = $urandom & ~(32'h1 << bits[j]);
         xfer(1, 16'h4004, d);
         s1 &= ~d;
         xfer(0, 16'h4004, 0);
         chk(rd, s1);
         xfer(1, 16'h4004, 32'h1 << bits[j]);
         s1 &= ~(1 << bits[j]);
         xfer(0, 16'h4004, 0);
         chk(rd, s1);
      end
      $display("test events done");
      xfer(1, 16'h400c, 5);
      host.fill(5);
      xfer(0, 16'h4008, 0);
      chk(rd, s2);
      host.fill(6);
      s2 = 1;
      xfer(0, 16'h4008, 0);
      chk(rd, s2);
      host.pulse(14);
      s2 = 3;
      xfer(0, 16'h4008, 0);
      chk(rd, s2);
      xfer(1, 16'h4004, 1);
      xfer(0, 16'h4004, 0);
      chk(rd, 1);
      for (int f = 0; f < 2; f++) begin
         fen = f;
         xfer(1, 16'h4006, f);
         xfer(0, 16'h4006, 0);
         chk(irq, irq_exp());
      end
      xfer(1, 16'h4008, 3);
      s2 = 0;
      xfer(0, 16'h4004, 0);
      chk(rd, 0);
      chk(irq, irq_exp());
      xfer(0, 16'h4020, 0);
      chk({rd[30:0], se}, 1);
      $display("test fifo done");
      stop_test();
   end
endmodule : testbench
bind ufis_top ufis_sva u_sva (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_ev(usb_ev),
   .irq(irq));
`default_nettype wire

// >>> ufis_top.sv
// The APB register port is this design's own decision.
`default_nettype none
module ufis_top (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [15:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire ufis_pkg::ufis_event_t usb_ev,
   output logic                      irq
);
   typedef struct packed {
      logic [7:0]  en_first;
      logic [1:0]  en_second;
      logic [6:0]  rx_thresh;
      logic [6:0]  tx_thresh;
      logic [1:0]  irq_mask;
      logic [31:0] rdata;
      logic        err;
      logic        irq;
   } ufis_state_t;

   ufis_state_t st_reg;
   ufis_state_t st_next;

   logic       acc;
   logic       wr;
   logic       hit;
   logic [7:0] set_first;
   logic [7:0] clr_first;
   logic [1:0] set_second;
   logic [1:0] clr_second;
   logic [7:0] flag_first;
   logic [1:0] flag_second;
   logic [7:0] status_first;
   logic       rx_hit;
   logic       tx_hit;

   assign acc = psel && penable;
   assign wr  = acc && pwrite;

   always_comb begin
      hit = 1'b1;
      case (paddr)
         ufis_pkg::OFS_STATUS_FIRST:  hit = 1'b1;
         ufis_pkg::OFS_FIFO_ENABLE:   hit = 1'b1;
         ufis_pkg::OFS_EVENT_ENABLE:  hit = 1'b1;
         ufis_pkg::OFS_STATUS_SECOND: hit = 1'b1;
         ufis_pkg::OFS_RX_THRESHOLD:  hit = 1'b1;
         ufis_pkg::OFS_IRQ_MASK:      hit = 1'b1;
         default:                     hit = 1'b0;
      endcase
   end

   // Arriving byte while count sits on threshold
   assign rx_hit = usb_ev.rx_byte
                   && (usb_ev.rx_count == st_reg.rx_thresh);
   assign tx_hit = usb_ev.tx_byte
                   && (usb_ev.tx_count == st_reg.tx_thresh);

   always_comb begin
      set_first = 8'h00;
      set_first[ufis_pkg::BIT_SUSPEND] = usb_ev.suspend_req;
      set_first[ufis_pkg::BIT_SOF]     = usb_ev.sof;
      set_first[ufis_pkg::BIT_EP4]     = usb_ev.ep4_sent;
      set_first[ufis_pkg::BIT_EP3]     = usb_ev.ep3_rcvd;
      set_first[ufis_pkg::BIT_EP2]     = usb_ev.ep2_read;
      set_first[ufis_pkg::BIT_EP1]     = usb_ev.ep1_written;
      set_second = 2'h0;
      set_second[ufis_pkg::BIT_RX_FULL] = rx_hit;
      set_second[ufis_pkg::BIT_TX_MTY]  = tx_hit;
      clr_first = 8'h00;
      clr_second = 2'h0;
      if (wr && paddr == ufis_pkg::OFS_STATUS_FIRST) begin
         // Zero bits leave flags alone
         clr_first = pwdata[7:0] & ufis_pkg::FIRST_W1C_MASK;
      end
      if (wr && paddr == ufis_pkg::OFS_STATUS_SECOND) begin
         clr_second = pwdata[1:0] & ufis_pkg::SECOND_W1C_MASK;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_first
         if (((ufis_pkg::FIRST_W1C_MASK >> g) & 8'h01) != 8'h00) begin : g_f
            ufis_w1c_bit u_bit (
               .clk   (clk),
               .rst_n (rst_n),
               .set   (set_first[g]),
               .clr   (clr_first[g]),
               .flag  (flag_first[g])
            );
         end else begin : g_z
            assign flag_first[g] = 1'b0;
         end
      end
      for (g = 0; g < 2; g++) begin : g_second
         ufis_w1c_bit u_bit (
            .clk   (clk),
            .rst_n (rst_n),
            .set   (set_second[g]),
            .clr   (clr_second[g]),
            .flag  (flag_second[g])
         );
      end
   endgenerate

   always_comb begin
      status_first = flag_first;
      status_first[ufis_pkg::BIT_UPPER] = |flag_second;
   end

   always_comb begin
      logic       lvl1;
      logic       lvl2;
      lvl1 = 1'b0;
      lvl2 = 1'b0;
      st_next = st_reg;
      st_next.rdata = 32'h0000_0000;
      st_next.err = 1'b0;
      if (wr) begin
         case (paddr)
            ufis_pkg::OFS_EVENT_ENABLE:
               st_next.en_first = pwdata[7:0] & ufis_pkg::FIRST_W1C_MASK;
            ufis_pkg::OFS_FIFO_ENABLE:
               st_next.en_second = pwdata[1:0];
            ufis_pkg::OFS_RX_THRESHOLD: begin
               st_next.rx_thresh = pwdata[6:0];
               st_next.tx_thresh = pwdata[14:8];
            end
            ufis_pkg::OFS_IRQ_MASK:
               st_next.irq_mask = pwdata[1:0];
            default: ;
         endcase
      end
      if (psel && !penable && !pwrite) begin
         case (paddr)
            ufis_pkg::OFS_STATUS_FIRST:
               st_next.rdata = {24'h000000, status_first};
            ufis_pkg::OFS_EVENT_ENABLE:
               st_next.rdata = {24'h000000, st_reg.en_first};
            ufis_pkg::OFS_FIFO_ENABLE:
               st_next.rdata = {30'h00000000, st_reg.en_second};
            ufis_pkg::OFS_STATUS_SECOND:
               st_next.rdata = {30'h00000000, flag_second};
            ufis_pkg::OFS_RX_THRESHOLD:
               st_next.rdata = {17'h00000, st_reg.tx_thresh,
                                1'b0, st_reg.rx_thresh};
            ufis_pkg::OFS_IRQ_MASK:
               st_next.rdata = {30'h00000000, st_reg.irq_mask};
            default: ;
         endcase
      end
      if (psel && !penable && !hit) begin
         st_next.err = 1'b1;
      end
      lvl1 = |(flag_first & st_reg.en_first);
      lvl2 = flag_second[ufis_pkg::BIT_RX_FULL]
             && st_reg.en_second[ufis_pkg::BIT_RX_FULL];
      lvl2 = lvl2 || (flag_second[ufis_pkg::BIT_TX_MTY]
             && st_reg.en_second[ufis_pkg::BIT_TX_MTY]);
      // Registered so irq never glitches on combinational decode
      st_next.irq = (lvl1 && st_reg.irq_mask[0])
                    || (lvl2 && st_reg.irq_mask[1]);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.en_first  <= ufis_pkg::RESET_BYTE;
         st_reg.en_second <= 2'h0;
         st_reg.rx_thresh <= ufis_pkg::RESET_THRESHOLD;
         st_reg.tx_thresh <= ufis_pkg::RESET_THRESHOLD;
         st_reg.irq_mask  <= ufis_pkg::RESET_MASK;
         st_reg.rdata     <= 32'h0000_0000;
         st_reg.err       <= 1'b0;
         st_reg.irq       <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata  = st_reg.rdata;
   assign pready  = acc;
   assign pslverr = acc && st_reg.err;
   assign irq     = st_reg.irq;
endmodule : ufis_top
`default_nettype wire

// >>> ufis_w1c_bit.sv
`default_nettype none
// Sticky flag, set beats a simultaneous clear
module ufis_w1c_bit (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic set,
   input  wire logic clr,
   output logic      flag
);
   logic flag_reg;
   logic flag_next;

   always_comb begin
      flag_next = flag_reg;
      if (clr) begin
         flag_next = 1'b0;
      end
      if (set) begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flag = flag_reg;
endmodule : ufis_w1c_bit
`default_nettype wire
